// ### src/cbbc_pkg.sv
// Constants and types for the branch and bit-clear execute block
package cbbc_pkg;
    localparam int unsigned PC_W   = 21;
    localparam int unsigned INSN_W = 16;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned MEM_AW = 12;
    localparam int unsigned BANK_W = 4;
    localparam int unsigned FLAG_W = 5;

    // Register byte offsets on the bus
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_INSN  = 8'h04;
    localparam logic [7:0] OFS_FLAGS = 8'h08;
    localparam logic [7:0] OFS_PC    = 8'h0c;
    localparam logic [7:0] OFS_BANK  = 8'h10;
    localparam logic [7:0] OFS_INDEX = 8'h14;
    localparam logic [7:0] OFS_MADDR = 8'h18;
    localparam logic [7:0] OFS_MDATA = 8'h1c;
    localparam logic [7:0] OFS_STAT  = 8'h20;

    // Field positions
    localparam int unsigned CTRL_EXT_BIT = 0;
    localparam int unsigned STAT_BUSY    = 0;
    localparam int unsigned STAT_TAKEN   = 1;
    localparam int unsigned STAT_BADOP   = 2;
    localparam int unsigned FLG_C        = 0;
    localparam int unsigned FLG_Z        = 2;
    localparam int unsigned FLG_OV       = 3;
    localparam int unsigned FLG_N        = 4;
    localparam int unsigned ACC_BIT      = 8;

    // Upper-byte opcodes and the bit-clear nibble
    localparam logic [7:0] OP_BRANCH_ON_CARRY        = 8'he2;
    localparam logic [7:0] OP_BRANCH_ON_NEGATIVE     = 8'he6;
    localparam logic [7:0] OP_BRANCH_ON_NO_CARRY     = 8'he3;
    localparam logic [7:0] OP_BRANCH_ON_NOT_NEGATIVE = 8'he7;
    localparam logic [7:0] OP_BRANCH_ON_NO_OVERFLOW  = 8'he5;
    localparam logic [7:0] OP_BRANCH_ON_NONZERO      = 8'he1;
    localparam logic [3:0] OP_FILE_BIT_CLEAR         = 4'h9;

    // Addressing
    localparam logic [7:0]        ACCESS_LIMIT   = 8'h5f;
    localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 4'hf;
    localparam logic [BANK_W-1:0] ACCESS_LO_BANK = 4'h0;
    localparam logic [PC_W-1:0]   PC_STEP        = 21'h000002;
    localparam logic [DATA_W-1:0] BIT_ONE        = 8'h01;

    // Reset values
    localparam logic [PC_W-1:0]   PC_RST    = 21'h000000;
    localparam logic [FLAG_W-1:0] FLAGS_RST = 5'h00;
    localparam logic [BANK_W-1:0] BANK_RST  = 4'h0;
    localparam logic [MEM_AW-1:0] INDEX_RST = 12'h000;

    // Quarter phases of one instruction cycle
    localparam logic [1:0] Q1 = 2'h0;
    localparam logic [1:0] Q2 = 2'h1;
    localparam logic [1:0] Q3 = 2'h2;
    localparam logic [1:0] Q4 = 2'h3;

    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_NOP} state_t;
endpackage

// ### src/data_ram.sv
// Byte-wide data memory with registered read data
`timescale 1ns/1ps
module data_ram
    import cbbc_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              we_in,
    input  wire logic              re_in,
    input  wire logic [MEM_AW-1:0] addr_in,
    input  wire logic [DATA_W-1:0] wdata_in,
    output logic      [DATA_W-1:0] rdata_out
);
    import cbbc_pkg::*;

    logic [DATA_W-1:0] mem [2**MEM_AW];

    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem[addr_in] <= wdata_in;
        end
    end

    // No reset on the array; the read register holds until the next read
    always_ff @(posedge clk_in) begin
        if (re_in) begin
            rdata_out <= mem[addr_in];
        end
    end
endmodule

// ### src/cond_branch_bit_clear_exec.sv
// Branch and bit-clear decode/execute block with an AHB-Lite register slave
//
// Implementation choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
module cond_branch_bit_clear_exec
    import cbbc_pkg::*;
(
    input  wire logic        REF_CLK_IN,
    input  wire logic        RST_IN,
    input  wire logic        HSEL_IN,
    input  wire logic [31:0] HADDR_IN,
    input  wire logic [1:0]  HTRANS_IN,
    input  wire logic        HWRITE_IN,
    input  wire logic [2:0]  HSIZE_IN,
    input  wire logic [31:0] HWDATA_IN,
    input  wire logic        HREADY_IN,
    output logic             HREADYOUT_OUT,
    output logic      [31:0] HRDATA_OUT,
    output logic             HRESP_OUT,
    output logic             BUSY_OUT
);
    import cbbc_pkg::*;

    state_t              st_q;
    logic [1:0]          ph_q;
    logic                busy;
    logic                q4;
    logic [INSN_W-1:0]   insn_q;
    logic [PC_W-1:0]     pc_q;
    logic [FLAG_W-1:0]   flags_q;
    logic [BANK_W-1:0]   bsr_q;
    logic [MEM_AW-1:0]   idx_q;
    logic [MEM_AW-1:0]   maddr_q;
    logic                ext_q;
    logic                taken_q;
    logic                clr_q;
    logic                bad_q;
    logic [MEM_AW-1:0]   ea_q;
    logic [DATA_W-1:0]   wdat_q;
    logic [7:0]          opc;
    logic [7:0]          fadr;
    logic [2:0]          bsel;
    logic                is_br;
    logic                cond;
    logic                is_clr;
    logic [MEM_AW-1:0]   ea;
    logic [PC_W-1:0]     offs;
    logic                dp_q;
    logic                dp_wr_q;
    logic [7:0]          dp_ofs_q;
    logic                rd_got_q;
    logic                ap_take;
    logic                mem_acc;
    logic                stall;
    logic                rd_wait;
    logic                wr_do;
    logic                launch;
    logic [31:0]         rdata;
    logic                m_we;
    logic                m_re;
    logic [MEM_AW-1:0]   m_addr;
    logic [DATA_W-1:0]   m_wd;
    logic [DATA_W-1:0]   m_rd;

    assign busy     = (st_q != ST_IDLE);
    assign BUSY_OUT = busy;
    assign q4       = (ph_q == Q4);
    assign opc      = insn_q[INSN_W-1:DATA_W];
    assign fadr     = insn_q[DATA_W-1:0];
    assign bsel     = insn_q[11:9];
    assign offs     = {{(PC_W-DATA_W-1){insn_q[DATA_W-1]}}, insn_q[DATA_W-1:0], 1'b0};

    // ---------------- AHB-Lite slave ----------------
    assign ap_take = HSEL_IN && HTRANS_IN[1] && HREADY_IN
                     && (HSIZE_IN == HSIZE_WORD);

    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            dp_q     <= 1'b0;
            dp_wr_q  <= 1'b0;
            dp_ofs_q <= 8'h00;
        end else if (HREADY_IN) begin
            dp_q     <= ap_take;
            dp_wr_q  <= HWRITE_IN;
            dp_ofs_q <= HADDR_IN[7:0];
        end
    end

    // Writes wait while an instruction runs so software never races the
    // engine on the program counter, flags or memory
    assign mem_acc = dp_q && (dp_ofs_q == OFS_MDATA);
    assign stall   = dp_q && busy && (dp_wr_q || mem_acc);
    assign rd_wait = mem_acc && !dp_wr_q && !rd_got_q;
    assign wr_do   = dp_q && dp_wr_q && !busy;
    assign launch  = wr_do && (dp_ofs_q == OFS_INSN);

    assign HREADYOUT_OUT = !(stall || rd_wait);
    assign HRESP_OUT     = 1'b0;

    // Memory window read costs one wait state
    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            rd_got_q <= 1'b0;
        end else begin
            rd_got_q <= rd_wait && !busy;
        end
    end

    always_comb begin
        rdata = 32'h00000000;
        case (dp_ofs_q)
            OFS_CTRL:  rdata[CTRL_EXT_BIT] = ext_q;
            OFS_INSN:  rdata[INSN_W-1:0] = insn_q;
            OFS_FLAGS: rdata[FLAG_W-1:0] = flags_q;
            OFS_PC:    rdata[PC_W-1:0] = pc_q;
            OFS_BANK:  rdata[BANK_W-1:0] = bsr_q;
            OFS_INDEX: rdata[MEM_AW-1:0] = idx_q;
            OFS_MADDR: rdata[MEM_AW-1:0] = maddr_q;
            OFS_MDATA: rdata[DATA_W-1:0] = m_rd;
            OFS_STAT: begin
                rdata[STAT_BUSY]  = busy;
                rdata[STAT_TAKEN] = taken_q;
                rdata[STAT_BADOP] = bad_q;
            end
            default: ;
        endcase
    end

    assign HRDATA_OUT = (dp_q && !dp_wr_q) ? rdata : 32'h00000000;

    // ---------------- Software registers ----------------
    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ext_q   <= 1'b0;
            bsr_q   <= BANK_RST;
            idx_q   <= INDEX_RST;
            maddr_q <= {MEM_AW{1'b0}};
            insn_q  <= {INSN_W{1'b0}};
        end else if (wr_do) begin
            case (dp_ofs_q)
                OFS_CTRL:  ext_q <= HWDATA_IN[CTRL_EXT_BIT];
                OFS_INSN:  insn_q <= HWDATA_IN[INSN_W-1:0];
                OFS_BANK:  bsr_q <= HWDATA_IN[BANK_W-1:0];
                OFS_INDEX: idx_q <= HWDATA_IN[MEM_AW-1:0];
                OFS_MADDR: maddr_q <= HWDATA_IN[MEM_AW-1:0];
                default: ;
            endcase
        end
    end

    // Only software writes the flags; the engine never does
    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            flags_q <= FLAGS_RST;
        end else if (wr_do && (dp_ofs_q == OFS_FLAGS)) begin
            flags_q <= HWDATA_IN[FLAG_W-1:0];
        end
    end

    // ---------------- Quarter-phase divider ----------------
    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ph_q <= Q1;
        end else if (!busy) begin
            ph_q <= Q1;
        end else begin
            ph_q <= ph_q + 2'h1;
        end
    end

    // ---------------- Decode ----------------
    always_comb begin
        is_br = 1'b1;
        cond  = 1'b0;
        case (opc)
            OP_BRANCH_ON_CARRY:        cond = flags_q[FLG_C];
            OP_BRANCH_ON_NEGATIVE:     cond = flags_q[FLG_N];
            OP_BRANCH_ON_NO_CARRY:     cond = !flags_q[FLG_C];
            OP_BRANCH_ON_NOT_NEGATIVE: cond = !flags_q[FLG_N];
            OP_BRANCH_ON_NO_OVERFLOW:  cond = !flags_q[FLG_OV];
            OP_BRANCH_ON_NONZERO:      cond = !flags_q[FLG_Z];
            default:                   is_br = 1'b0;
        endcase
    end

    assign is_clr = (insn_q[15:12] == OP_FILE_BIT_CLEAR);

    // Effective file address
    always_comb begin
        if (insn_q[ACC_BIT]) begin
            ea = {bsr_q, fadr};
        end else if (ext_q && (fadr <= ACCESS_LIMIT)) begin
            ea = idx_q + {ACCESS_LO_BANK, fadr};
        end else if (fadr <= ACCESS_LIMIT) begin
            ea = {ACCESS_LO_BANK, fadr};
        end else begin
            ea = {ACCESS_HI_BANK, fadr};
        end
    end

    // Decode in Q1: the verdict and address hold for the whole cycle
    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            taken_q <= 1'b0;
            clr_q   <= 1'b0;
            bad_q   <= 1'b0;
            ea_q    <= {MEM_AW{1'b0}};
        end else if (st_q == ST_EXEC && ph_q == Q1) begin
            taken_q <= is_br && cond;
            clr_q   <= is_clr;
            bad_q   <= !is_br && !is_clr;
            ea_q    <= ea;
        end
    end

    // Q3 process: clear the chosen bit in the value read at Q2
    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            wdat_q <= {DATA_W{1'b0}};
        end else if (st_q == ST_EXEC && ph_q == Q3) begin
            wdat_q <= m_rd & ~(BIT_ONE << bsel);
        end
    end

    // ---------------- Sequencer ----------------
    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            st_q <= ST_IDLE;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (launch) begin
                        st_q <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    if (q4) begin
                        st_q <= taken_q ? ST_NOP : ST_IDLE;
                    end
                end
                ST_NOP: begin
                    if (q4) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // Program counter: the engine writes it only in Q4 of the executing cycle; software writes it while idle
    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            pc_q <= PC_RST;
        end else if (st_q == ST_EXEC && q4) begin
            if (taken_q) begin
                pc_q <= pc_q + PC_STEP + offs;
            end else begin
                pc_q <= pc_q + PC_STEP;
            end
        end else if (wr_do && (dp_ofs_q == OFS_PC)) begin
            pc_q <= HWDATA_IN[PC_W-1:0];
        end
    end

    // ---------------- Data memory port ----------------
    // Engine owns the port while busy; the window only works when idle
    assign m_re   = (st_q == ST_EXEC && ph_q == Q2 && clr_q)
                    || (rd_wait && !busy);
    assign m_we   = (st_q == ST_EXEC && q4 && clr_q)
                    || (wr_do && (dp_ofs_q == OFS_MDATA));
    assign m_addr = busy ? ea_q : maddr_q;
    assign m_wd   = busy ? wdat_q : HWDATA_IN[DATA_W-1:0];

    data_ram u_ram (
        .clk_in    (REF_CLK_IN),
        .we_in     (m_we),
        .re_in     (m_re),
        .addr_in   (m_addr),
        .wdata_in  (m_wd),
        .rdata_out (m_rd)
    );

    // ---------------- Assertions ----------------
    default clocking cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (RST_IN);

    sequence s_decoded(logic [7:0] op);
        st_q == ST_EXEC && ph_q == Q2 && opc == op;
    endsequence

    sequence s_taken_end;
        st_q == ST_EXEC && q4 && taken_q;
    endsequence

    sequence s_nop_cycle;
        (st_q == ST_NOP)[*4];
    endsequence

    property p_verdict(logic [7:0] op, logic want);
        s_decoded(op) |-> taken_q == want;
    endproperty

    carry_verdict_a: assert property (
        p_verdict(OP_BRANCH_ON_CARRY, flags_q[FLG_C]))
        else $error("carry branch verdict wrong");
    neg_verdict_a: assert property (
        p_verdict(OP_BRANCH_ON_NEGATIVE, flags_q[FLG_N]))
        else $error("negative branch verdict wrong");
    nocarry_verdict_a: assert property (
        p_verdict(OP_BRANCH_ON_NO_CARRY, !flags_q[FLG_C]))
        else $error("no-carry branch verdict wrong");
    notneg_verdict_a: assert property (
        p_verdict(OP_BRANCH_ON_NOT_NEGATIVE, !flags_q[FLG_N]))
        else $error("not-negative branch verdict wrong");
    noovf_verdict_a: assert property (
        p_verdict(OP_BRANCH_ON_NO_OVERFLOW, !flags_q[FLG_OV]))
        else $error("no-overflow branch verdict wrong");
    nonzero_verdict_a: assert property (
        p_verdict(OP_BRANCH_ON_NONZERO, !flags_q[FLG_Z]))
        else $error("nonzero branch verdict wrong");

    branch_target_a: assert property (
        s_taken_end |=> pc_q - $past(pc_q) == PC_STEP + offs)
        else $error("taken branch target wrong");
    nonzero_jump_a: assert property (
        s_decoded(OP_BRANCH_ON_NONZERO) ##0 taken_q ##2 1'b1
        |=> pc_q - $past(pc_q, 3) == PC_STEP + offs)
        else $error("nonzero branch target wrong");
    taken_timing_a: assert property (
        s_taken_end |=> s_nop_cycle ##1 st_q == ST_IDLE)
        else $error("taken branch not two cycles");
    untaken_timing_a: assert property (
        launch |=> (st_q == ST_EXEC)[*4] ##1
        (taken_q || st_q == ST_IDLE))
        else $error("untaken branch not one cycle");
    flags_stable_a: assert property (
        busy |=> $stable(flags_q))
        else $error("flags changed during execute");
    clear_write_a: assert property (
        st_q == ST_EXEC && ph_q == Q2 && clr_q |-> m_re ##2
        m_we && !m_wd[bsel] && ((m_wd | (BIT_ONE << bsel))
        == ($past(m_rd) | (BIT_ONE << bsel))))
        else $error("bit clear read/write wrong");
    branch_nowrite_a: assert property (
        st_q == ST_EXEC && !clr_q && ph_q != Q1 |-> !m_we)
        else $error("branch wrote data memory");
    bank_addr_a: assert property (
        st_q == ST_EXEC && ph_q == Q2 && clr_q && insn_q[ACC_BIT]
        |-> m_addr == {bsr_q, fadr})
        else $error("banked address wrong");
    indexed_addr_a: assert property (
        st_q == ST_EXEC && ph_q == Q2 && clr_q && !insn_q[ACC_BIT]
        && ext_q && fadr <= ACCESS_LIMIT
        |-> m_addr == idx_q + {ACCESS_LO_BANK, fadr})
        else $error("indexed address wrong");
endmodule

// ### test/tb_top.sv
// Self-checking bench for the branch and bit-clear execute block
`timescale 1ns/1ps
module tb_top;
    import cbbc_pkg::*;
    localparam logic [7:0] OP_TAB [6] = '{OP_BRANCH_ON_CARRY, OP_BRANCH_ON_NEGATIVE,
        OP_BRANCH_ON_NO_CARRY, OP_BRANCH_ON_NOT_NEGATIVE, OP_BRANCH_ON_NO_OVERFLOW,
        OP_BRANCH_ON_NONZERO};
    logic        clk;
    logic        rst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
    logic [31:0] hrdata;
    logic        hresp;
    logic        busy;
    logic [31:0] d;
    int          mismatches;
    int          checks;

    cond_branch_bit_clear_exec dut (
        .REF_CLK_IN    (clk),
        .RST_IN        (rst),
        .HSEL_IN       (hsel),
        .HADDR_IN      (haddr),
        .HTRANS_IN     (htrans),
        .HWRITE_IN     (hwrite),
        .HSIZE_IN      (hsize),
        .HWDATA_IN     (hwdata),
        .HREADY_IN     (hready),
        .HREADYOUT_OUT (hready),
        .HRDATA_OUT    (hrdata),
        .HRESP_OUT     (hresp),
        .BUSY_OUT      (busy)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Entered just after a rising edge; returns at the edge that ends the data phase
    task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                       input logic [2:0] sz, output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {24'h0, ofs};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize  <= sz;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] ofs, input logic [31:0] v);
        logic [31:0] x;
        bus(1'b1, ofs, v, HSIZE_WORD, x);
    endtask

    task automatic rd(input logic [7:0] ofs, output logic [31:0] v);
        bus(1'b0, ofs, 32'h0, HSIZE_WORD, v);
    endtask

    // Launch one instruction and count the cycles that busy stays high
    task automatic run(input logic [15:0] insn, output int cnt);
        wr(OFS_INSN, {16'h0, insn});
        cnt = 0;
        @(negedge clk);
        while (busy === 1'b1 && cnt < 20) begin
            cnt++;
            @(negedge clk);
        end
        @(posedge clk);
    endtask

    function automatic logic will_take(input logic [7:0] op, input logic [4:0] fl);
        case (op)
            OP_BRANCH_ON_CARRY:        return fl[FLG_C];
            OP_BRANCH_ON_NEGATIVE:     return fl[FLG_N];
            OP_BRANCH_ON_NO_CARRY:     return !fl[FLG_C];
            OP_BRANCH_ON_NOT_NEGATIVE: return !fl[FLG_N];
            OP_BRANCH_ON_NO_OVERFLOW:  return !fl[FLG_OV];
            OP_BRANCH_ON_NONZERO:      return !fl[FLG_Z];
            default:                   return 1'b0;
        endcase
    endfunction

    function automatic logic [11:0] eff_addr(input logic a, input logic ext,
        input logic [7:0] f, input logic [3:0] bank, input logic [11:0] idx);
        if (a)
            return {bank, f};
        if (ext && f <= ACCESS_LIMIT)
            return idx + {4'h0, f};
        if (f <= ACCESS_LIMIT)
            return {ACCESS_LO_BANK, f};
        return {ACCESS_HI_BANK, f};
    endfunction

    task automatic branch_case(input logic [7:0] op, input logic [4:0] fl, input logic [7:0] n,
                               input logic [20:0] pc);
        logic        tk;
        logic [20:0] exp_pc;
        int          cnt;
        tk = will_take(op, fl);
        exp_pc = pc + PC_STEP + (tk ? {{12{n[7]}}, n, 1'b0} : 21'h0);
        wr(OFS_FLAGS, {27'h0, fl});
        wr(OFS_PC, {11'h0, pc});
        run({op, n}, cnt);
        chk(32'(cnt), tk ? 32'd8 : 32'd4);
        rd(OFS_PC, d);
        chk(d, {11'h0, exp_pc});
        rd(OFS_FLAGS, d);
        chk(d, {27'h0, fl});
        rd(OFS_STAT, d);
        chk({31'h0, d[STAT_TAKEN]}, {31'h0, tk});
    endtask

    // A decoy byte at the address a wrong mode would pick must survive untouched
    task automatic clear_case(input logic a, input logic ext, input logic [7:0] f,
                              input logic [2:0] b, input logic [7:0] v);
        logic [3:0]  bank;
        logic [11:0] idx;
        logic [11:0] ea;
        logic [11:0] alt;
        logic [7:0]  cleared;
        logic [4:0]  fl;
        logic [20:0] pc;
        int          cnt;
        bank = 4'($urandom);
        idx = 12'($urandom);
        fl = 5'($urandom);
        ea = eff_addr(a, ext, f, bank, idx);
        alt = a ? eff_addr(1'b0, ext, f, bank, idx) : {bank, f};
        cleared = v & ~(BIT_ONE << b);
        wr(OFS_CTRL, {31'h0, ext});
        wr(OFS_BANK, {28'h0, bank});
        wr(OFS_INDEX, {20'h0, idx});
        wr(OFS_FLAGS, {27'h0, fl});
        wr(OFS_MADDR, {20'h0, alt});
        wr(OFS_MDATA, {24'h0, ~v});
        wr(OFS_MADDR, {20'h0, ea});
        wr(OFS_MDATA, {24'h0, v});
        rd(OFS_PC, d);
        pc = d[20:0];
        run({OP_FILE_BIT_CLEAR, b, a, f}, cnt);
        chk(32'(cnt), 32'd4);
        rd(OFS_MDATA, d);
        chk(d, {24'h0, cleared});
        wr(OFS_MADDR, {20'h0, alt});
        rd(OFS_MDATA, d);
        chk(d, {24'h0, (alt == ea) ? cleared : ~v});
        rd(OFS_PC, d);
        chk(d, {11'h0, pc + PC_STEP});
        rd(OFS_FLAGS, d);
        chk(d, {27'h0, fl});
    endtask

    initial begin
        int cnt;
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = 32'h0;
        mismatches = 0;
        checks = 0;
        void'($urandom(32'h02c79749));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(OFS_PC, d);
        chk(d, {11'h0, PC_RST});
        rd(OFS_FLAGS, d);
        chk(d, {27'h0, FLAGS_RST});
        rd(OFS_STAT, d);
        chk(d, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        // Unmapped offset: write dropped, reads back zero
        wr(8'h40, $urandom);
        rd(8'h40, d);
        chk(d, 32'h0);
        // Every branch opcode both ways, at the offset extremes and across the wrap
        for (int i = 0; i < 6; i++) begin
            branch_case(OP_TAB[i], 5'h00, 8'h7f, 21'h1ffffe);
            branch_case(OP_TAB[i], 5'h1f, 8'h80, 21'h000000);
        end
        for (int i = 0; i < 24; i++)
            branch_case(OP_TAB[$urandom_range(5)], 5'($urandom), 8'($urandom),
                        {20'($urandom), 1'b0});
        clear_case(1'b0, 1'b1, 8'h5f, 3'h7, 8'hff);
        clear_case(1'b0, 1'b1, 8'h60, 3'h0, 8'hff);
        clear_case(1'b0, 1'b0, 8'h5f, 3'h3, 8'hc7);
        clear_case(1'b0, 1'b0, 8'h60, 3'h6, 8'h5a);
        clear_case(1'b1, 1'b1, 8'h10, 3'h1, 8'hff);
        for (int i = 0; i < 12; i++)
            clear_case(1'($urandom), 1'($urandom), 8'($urandom), 3'($urandom), 8'($urandom));
        // Undefined opcode just steps past itself and flags itself
        wr(OFS_PC, 32'h100);
        run(16'hff00, cnt);
        rd(OFS_STAT, d);
        chk({31'h0, d[STAT_BADOP]}, 32'h1);
        rd(OFS_PC, d);
        chk(d, 32'h102);
        // Side registers keep only their low bits; a byte-wide write is dropped
        wr(OFS_CTRL, 32'hffffffff);
        rd(OFS_CTRL, d);
        chk(d, 32'h1);
        wr(OFS_INDEX, 32'hffffffff);
        bus(1'b1, OFS_INDEX, 32'h0, 3'h0, d);
        rd(OFS_INDEX, d);
        chk(d, 32'h00000fff);
        // Reads see a running branch live; a write waits until it has finished
        wr(OFS_FLAGS, 32'h0);
        wr(OFS_INSN, {16'h0, OP_BRANCH_ON_NO_CARRY, 8'h10});
        rd(OFS_STAT, d);
        chk(d, 32'h3);
        wr(OFS_PC, 32'h40);
        chk({31'h0, busy}, 32'h0);
        rd(OFS_PC, d);
        chk(d, 32'h40);
        conclude();
    end

    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        conclude();
    end
endmodule
